// *** asmr_pkg.sv ***
// Package with offsets, field positions and carriers of the amplifier status monitor bank
package asmr_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_CH = 2;

    // Register offsets
    localparam logic [7:0] CH0_MODE_MONITOR_ADDR       = 8'h60;
    localparam logic [7:0] CH0_PROTECTION_MONITOR_ADDR = 8'h61;
    localparam logic [7:0] CH0_MODULATION_INDEX_ADDR   = 8'h62;
    localparam logic [7:0] CH1_MODE_MONITOR_ADDR       = 8'h64;
    localparam logic [7:0] CH1_PROTECTION_MONITOR_ADDR = 8'h65;
    localparam logic [7:0] CH1_MODULATION_INDEX_ADDR   = 8'h66;
    localparam logic [7:0] FAULT_STICKY_ADDR           = 8'h6d;
    localparam logic [7:0] OUTPUT_CONFIG_MONITOR_ADDR  = 8'h75;
    localparam logic [7:0] FAULT_LIVE_ADDR             = 8'h7c;

    // Reset values
    localparam logic [7:0] REG_RESET   = 8'h00;
    localparam logic [7:0] UNMAPPED_RD = 8'h00;

    // Mode monitor field positions
    localparam int RATE_LSB    = 4;
    localparam int RATE_W      = 3;
    localparam int PROFILE_LSB = 0;
    localparam int PROFILE_W   = 2;

    // Protection monitor bit positions
    localparam int SILENCED_BIT     = 5;
    localparam int LOGIC_SUPPLY_BIT = 4;
    localparam int STAGE_SUPPLY_BIT = 3;
    localparam int SECOND_FLYCAP_BIT = 2;
    localparam int FIRST_FLYCAP_BIT = 1;
    localparam int OVERCURRENT_BIT  = 0;

    // Output configuration select width
    localparam int OUTCFG_W = 3;

    // Fault bit positions, shared by live and sticky registers
    localparam int FLT_FLYCAP_OV    = 0;
    localparam int FLT_OVERCURRENT  = 1;
    localparam int FLT_PLL          = 2;
    localparam int FLT_UNDERVOLTAGE = 3;
    localparam int FLT_OTEMP_WARN   = 4;
    localparam int FLT_OTEMP_ERR    = 5;
    localparam int FLT_PIN_SHORT    = 6;
    localparam int FLT_DC           = 7;
    localparam int FLT_W            = 8;

    // Per-channel status from the power stage
    typedef struct packed {
        logic [2:0] switch_rate_state;
        logic [1:0] power_profile_state;
        logic       silenced_flag;
        logic       logic_supply_good;
        logic       stage_supply_good;
        logic       second_flycap_good;
        logic       first_flycap_good;
        logic       overcurrent_event;
        logic [7:0] mod_index;
    } asmr_chan_t;

    // Register read request
    typedef struct packed {
        logic       rd_en;
        logic [7:0] addr;
    } asmr_rd_req_t;

endpackage

// *** asmr_sync.sv ***
// Two-flop synchroniser bank for asynchronous status inputs
module asmr_sync
    import asmr_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clock,  // Core clock
    input  wire logic         arst_n, // Async reset, active low
    input  wire logic [W-1:0] d,      // Asynchronous inputs
    output logic      [W-1:0] q       // Synchronised outputs
);

    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

// *** asmr_chan_fmt.sv ***
// Packs one channel's status into its three monitor bytes
module asmr_chan_fmt
    import asmr_pkg::*;
(
    input  asmr_chan_t       chan,      // Synchronised channel status
    output logic [7:0]       mode_byte, // Mode monitor byte
    output logic [7:0]       prot_byte, // Protection monitor byte
    output logic [7:0]       mod_byte   // Modulation index byte
);

    // Mode byte: rate state high, power profile low, others zero
    always_comb begin
        mode_byte = REG_RESET;
        mode_byte[RATE_LSB +: RATE_W]       = chan.switch_rate_state;
        mode_byte[PROFILE_LSB +: PROFILE_W] = chan.power_profile_state;
    end

    // Protection byte: one flag per bit, upper bits zero
    always_comb begin
        prot_byte = REG_RESET;
        prot_byte[SILENCED_BIT]      = chan.silenced_flag;
        prot_byte[LOGIC_SUPPLY_BIT]  = chan.logic_supply_good;
        prot_byte[STAGE_SUPPLY_BIT]  = chan.stage_supply_good;
        prot_byte[SECOND_FLYCAP_BIT] = chan.second_flycap_good;
        prot_byte[FIRST_FLYCAP_BIT]  = chan.first_flycap_good;
        prot_byte[OVERCURRENT_BIT]   = chan.overcurrent_event;
    end

    // Index is already linear 0..255, passed as is
    assign mod_byte = chan.mod_index;

endmodule

// *** asmr_regs.sv ***
// Read-only status and monitor register bank of a two-channel class-D amplifier
// Operation
// - Mode monitor bits 6:4 at 0x60/0x64 show current frequency mode.
// - Mode monitor bits 1:0 show the power mode in use.
// - Protection monitor bit 5 shows mute state of the channel.
// - Protection monitor bit 4 shows logic supply within range.
// - Protection monitor bit 3 shows stage supply within range.
// - Protection monitor bit 2 shows second flying capacitor check passes.
// - Protection monitor bit 1 shows first flying capacitor check passes.
// - Protection monitor bit 0 flags an over-current event.
// - Live modulation index at 0x62/0x66, 0..1 mapped to 0..255.
// - Live fault register at 0x7C shows each source's present state.
// - Fault bits: flycap OV, OC, PLL, UV, OT warn, OT err, short, DC.
// - Sticky fault register at 0x6D holds history in same bit positions.
// - Register 0x75 bits 2:0 show output configuration select pins.
module asmr_regs
    import asmr_pkg::*;
(
    input  wire logic                clock,         // 200 MHz core clock
    input  wire logic                arst_n,        // Async reset, active low
    input  asmr_chan_t               ch0_status,    // Channel 0 status, async
    input  asmr_chan_t               ch1_status,    // Channel 1 status, async
    input  wire logic [FLT_W-1:0]    fault_src,     // Live fault sources, async
    input  wire logic [OUTCFG_W-1:0] outcfg_pins,   // Output config select pins
    input  wire logic                fault_clear,   // Clear strobe, core clock pulse
    input  asmr_rd_req_t             rd_req,        // Read request, core clock
    output logic [DATA_W-1:0]        rd_data,       // Read data, registered
    output logic                     rd_valid       // Read data valid pulse
);

    localparam int CH_W = $bits(asmr_chan_t);

    // All asynchronous inputs pass two flops before use
    logic [CH_W-1:0]     ch_sync [NUM_CH];
    asmr_chan_t          ch_view [NUM_CH];
    logic [FLT_W-1:0]    fault_live;
    logic [OUTCFG_W-1:0] outcfg_sync;
    logic [FLT_W-1:0]    fault_sticky;
    logic [FLT_W-1:0]    next_fault_sticky;
    logic [7:0]          mode_b [NUM_CH];
    logic [7:0]          prot_b [NUM_CH];
    logic [7:0]          mod_b  [NUM_CH];
    logic [CH_W-1:0]     ch_raw [NUM_CH];

    assign ch_raw[0] = ch0_status;
    assign ch_raw[1] = ch1_status;

    // One synchroniser and formatter per channel
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        asmr_sync #(
            .W (CH_W)
        ) u_sync (
            .clock  (clock),
            .arst_n (arst_n),
            .d      (ch_raw[c]),
            .q      (ch_sync[c])
        );
        assign ch_view[c] = asmr_chan_t'(ch_sync[c]);
        asmr_chan_fmt u_fmt (
            .chan      (ch_view[c]),
            .mode_byte (mode_b[c]),
            .prot_byte (prot_b[c]),
            .mod_byte  (mod_b[c])
        );
    end

    // Fault sources are levels from protection circuits
    asmr_sync #(
        .W (FLT_W)
    ) u_fault_sync (
        .clock  (clock),
        .arst_n (arst_n),
        .d      (fault_src),
        .q      (fault_live)
    );

    // Configuration pins sampled continuously
    asmr_sync #(
        .W (OUTCFG_W)
    ) u_cfg_sync (
        .clock  (clock),
        .arst_n (arst_n),
        .d      (outcfg_pins),
        .q      (outcfg_sync)
    );

    // Set wins over clear so a fault arriving during the clear is kept
    assign next_fault_sticky = fault_clear ? fault_live
                                           : (fault_sticky | fault_live);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            fault_sticky <= REG_RESET;
        end else begin
            fault_sticky <= next_fault_sticky;
        end
    end

    // Address decode; reads only select, never modify state
    logic       hit_m0;
    logic       hit_p0;
    logic       hit_i0;
    logic       hit_m1;
    logic       hit_p1;
    logic       hit_i1;
    logic       hit_st;
    logic       hit_cf;
    logic       hit_lv;
    logic [7:0] cfg_byte;
    logic [7:0] sel_data;

    assign hit_m0 = (rd_req.addr == CH0_MODE_MONITOR_ADDR);
    assign hit_p0 = (rd_req.addr == CH0_PROTECTION_MONITOR_ADDR);
    assign hit_i0 = (rd_req.addr == CH0_MODULATION_INDEX_ADDR);
    assign hit_m1 = (rd_req.addr == CH1_MODE_MONITOR_ADDR);
    assign hit_p1 = (rd_req.addr == CH1_PROTECTION_MONITOR_ADDR);
    assign hit_i1 = (rd_req.addr == CH1_MODULATION_INDEX_ADDR);
    assign hit_st = (rd_req.addr == FAULT_STICKY_ADDR);
    assign hit_cf = (rd_req.addr == OUTPUT_CONFIG_MONITOR_ADDR);
    assign hit_lv = (rd_req.addr == FAULT_LIVE_ADDR);

    // Upper bits of the config byte read as zero
    assign cfg_byte = {{(DATA_W-OUTCFG_W){1'b0}}, outcfg_sync};

    // Unmapped addresses read as zero
    assign sel_data = hit_m0 ? mode_b[0]    :
                      hit_p0 ? prot_b[0]    :
                      hit_i0 ? mod_b[0]     :
                      hit_m1 ? mode_b[1]    :
                      hit_p1 ? prot_b[1]    :
                      hit_i1 ? mod_b[1]     :
                      hit_st ? fault_sticky :
                      hit_cf ? cfg_byte     :
                      hit_lv ? fault_live   :
                               UNMAPPED_RD;

    // Registered answer one cycle after the request; no clear on read
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rd_data  <= REG_RESET;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_req.rd_en;
            if (rd_req.rd_en) begin
                rd_data <= sel_data;
            end
        end
    end

endmodule

// *** asmr_regs_assertions.sv ***
// Checker of read timing and field mapping of the status monitor bank
module asmr_regs_checker
    import asmr_pkg::*;
(
    input wire logic                clock,       // Core clock
    input wire logic                arst_n,      // Async reset, active low
    input asmr_chan_t               ch0_status,  // Channel 0 status
    input asmr_chan_t               ch1_status,  // Channel 1 status
    input wire logic [FLT_W-1:0]    fault_src,   // Fault sources
    input wire logic [OUTCFG_W-1:0] outcfg_pins, // Config select pins
    input wire logic                fault_clear, // Clear strobe
    input asmr_rd_req_t             rd_req,      // Read request
    input wire logic [DATA_W-1:0]   rd_data,     // Read data
    input wire logic                rd_valid     // Read valid
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    // Read taken at one offset; inputs show three edges back through the synchroniser
    sequence rd_at(logic [7:0] a);
        rd_req.rd_en && rd_req.addr == a;
    endsequence
    read_answer_a: assert property (rd_req.rd_en |=> rd_valid)
        else $error("read not answered");
    idle_quiet_a: assert property (!rd_req.rd_en |=> !rd_valid && $stable(rd_data))
        else $error("output moved without a read");
    live_fault_a: assert property (rd_at(FAULT_LIVE_ADDR) |=> rd_data == $past(fault_src, 3))
        else $error("live fault byte wrong");
    ch0_mode_a: assert property (rd_at(CH0_MODE_MONITOR_ADDR) |=> rd_data ==
        {1'b0, $past(ch0_status[18:16], 3), 2'b00, $past(ch0_status[15:14], 3)})
        else $error("channel 0 mode byte wrong");
    ch1_prot_a: assert property (rd_at(CH1_PROTECTION_MONITOR_ADDR) |=>
        rd_data == {2'b00, $past(ch1_status[13:8], 3)})
        else $error("channel 1 protection byte wrong");
    ch0_modidx_a: assert property (rd_at(CH0_MODULATION_INDEX_ADDR) |=>
        rd_data == $past(ch0_status.mod_index, 3))
        else $error("channel 0 modulation byte wrong");
    outcfg_mirror_a: assert property (rd_at(OUTPUT_CONFIG_MONITOR_ADDR) |=>
        rd_data == {5'h00, $past(outcfg_pins, 3)})
        else $error("output config byte wrong");
    sticky_set_a: assert property (rd_at(FAULT_STICKY_ADDR) |=>
        (rd_data & $past(fault_src, 4)) == $past(fault_src, 4))
        else $error("sticky fault bit missing");
    unmapped_zero_a: assert property (rd_req.rd_en && rd_req.addr < 8'h60 |=>
        rd_data == UNMAPPED_RD)
        else $error("unmapped read not zero");
endmodule

bind asmr_regs asmr_regs_checker chk (.clock(clock), .arst_n(arst_n), .ch0_status(ch0_status),
    .ch1_status(ch1_status), .fault_src(fault_src), .outcfg_pins(outcfg_pins),
    .fault_clear(fault_clear), .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid));

// *** test_asmr_regs.sv ***
// Self-checking bench of the amplifier status monitor bank
module test_asmr_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import asmr_pkg::*;
    logic                clock;
    logic                arst_n;
    asmr_chan_t          ch0_status;
    asmr_chan_t          ch1_status;
    logic [FLT_W-1:0]    fault_src;
    logic [OUTCFG_W-1:0] outcfg_pins;
    logic                fault_clear;
    asmr_rd_req_t        rd_req;
    logic [DATA_W-1:0]   rd_data;
    logic                rd_valid;
    logic [7:0]          acc;
    int                  mismatches;
    int                  n_compared;
    asmr_regs dut (.clock(clock), .arst_n(arst_n), .ch0_status(ch0_status),
        .ch1_status(ch1_status), .fault_src(fault_src), .outcfg_pins(outcfg_pins),
        .fault_clear(fault_clear), .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid));
    // 200 MHz core clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // One read; bounded wait for the answer, then compare
    task automatic chk(input logic [7:0] a, input logic [7:0] exp);
        int n;
        @(posedge clock);
        rd_req <= '{1'b1, a};
        @(posedge clock);
        rd_req.rd_en <= 1'b0;
        // Valid stands only one cycle after the taking edge, so look just past each edge
        for (n = 0; n < 4; n++) begin
            #1;
            if (rd_valid === 1'b1) break;
            @(posedge clock);
        end
        n_compared++;
        if (n == 4) begin
            mismatches++;
            $display("mismatch rd_valid %h expected 1 seen %b", a, rd_valid);
            print_verdict();
        end else if (rd_data !== exp) begin
            mismatches++;
            $display("mismatch reg %h expected %h seen %h", a, exp, rd_data);
        end
    endtask
    // Fault sources change, then wait out the synchroniser
    task automatic set_flt(input logic [7:0] v);
        @(posedge clock);
        fault_src <= v;
        repeat (4) @(posedge clock);
    endtask
    task automatic clr();
        @(posedge clock);
        fault_clear <= 1'b1;
        @(posedge clock);
        fault_clear <= 1'b0;
    endtask
    initial begin
        arst_n = 1'b0;
        ch0_status = '0;
        ch1_status = '0;
        fault_src = 8'h00;
        outcfg_pins = 3'h0;
        fault_clear = 1'b0;
        rd_req = '0;
        acc = 8'h00;
        mismatches = 0;
        n_compared = 0;
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        // Reset values, holes in the map read as zero
        for (int a = 8'h60; a < 8'h80; a++) chk(a[7:0], REG_RESET);
        chk(8'h00, UNMAPPED_RD);
        $display("test reset values done");
        // Opposite bit patterns on the two channels, except the modulation index (a5 vs ff), catch swapped fields
        @(posedge clock);
        ch0_status <= '{3'h5, 2'h2, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 8'ha5};
        ch1_status <= '{3'h2, 2'h1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 8'hff};
        outcfg_pins <= 3'h6;
        repeat (4) @(posedge clock);
        chk(CH0_MODE_MONITOR_ADDR, 8'h52);
        chk(CH0_PROTECTION_MONITOR_ADDR, 8'h2a);
        chk(CH0_MODULATION_INDEX_ADDR, 8'ha5);
        chk(CH1_MODE_MONITOR_ADDR, 8'h21);
        chk(CH1_PROTECTION_MONITOR_ADDR, 8'h15);
        chk(CH1_MODULATION_INDEX_ADDR, 8'hff);
        chk(OUTPUT_CONFIG_MONITOR_ADDR, 8'h06);
        chk(8'h63, UNMAPPED_RD);
        $display("test channel fields done");
        // Each fault alone: live follows, sticky keeps history, reads clear nothing
        for (int i = 0; i < FLT_W; i++) begin
            set_flt(8'h01 << i);
            chk(FAULT_LIVE_ADDR, 8'h01 << i);
            set_flt(8'h00);
            acc = acc | (8'h01 << i);
            chk(FAULT_LIVE_ADDR, 8'h00);
            chk(FAULT_STICKY_ADDR, acc);
            chk(FAULT_STICKY_ADDR, acc);
        end
        // Clear with one fault still active keeps that bit
        set_flt(8'h80);
        clr();
        chk(FAULT_STICKY_ADDR, 8'h80);
        set_flt(8'h00);
        clr();
        chk(FAULT_STICKY_ADDR, 8'h00);
        $display("test faults done");
        print_verdict();
    end
endmodule
